// *** include/rx_status_early_tx_regs_consts.vh ***
// Register offsets, field positions, reset values and limits of the queue register bank
`ifndef RX_STATUS_EARLY_TX_REGS_CONSTS_VH
`define RX_STATUS_EARLY_TX_REGS_CONSTS_VH

// Register byte offsets
`define OFS_RX_STATUS 8'h04
`define OFS_RX_BYTE_COUNT 8'h06
`define OFS_EARLY_TX 8'h08
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_CLEAR 8'h12
`define OFS_IRQ_ENABLE 8'h14

// Receive status fields
`define BIT_FRAME_VALID 15
`define BIT_BROADCAST 7
`define BIT_GROUP_ADDR 6
`define BIT_INDIV_ADDR 5
`define BIT_SYMBOL_ERR 4
`define BIT_FRAME_TYPE 3
`define BIT_OVERSIZE 2
`define BIT_SHORT_FRAME 1
`define BIT_FCS_ERR 0

// Early transmit fields
`define BIT_ETX_ENABLE 7
`define ETX_THR_MSB 4
`define ETX_THR_UNIT_SHIFT 6
`define ETX_ENABLE_RESET 1'h0
`define ETX_THR_RESET 5'h00

// Frame limits in bytes
`define MAX_FRAME_BYTES 11'h77c
`define TYPE_FIELD_LIMIT 16'h05dc

// Interrupt status bits
`define IRQ_RX_READY 0
`define IRQ_RX_DISCARD 1
`define IRQ_RX_OVERRUN 2
`define IRQ_TX_START 3
`define IRQ_WIDTH 4

`endif

// *** hw/rx_status_early_tx_regs.v ***
// Receive status, receive byte count and early transmit registers of the queue unit
`default_nettype none
`include "rx_status_early_tx_regs_consts.vh"

module rx_status_early_tx_regs #(
	parameter ADDR_W = 8,
	parameter CNT_W = 11
) (
	input wire clk_i,
	input wire resetn_i,
	// Register port
	input wire [ADDR_W-1:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	// Receive path: one pulse per finished frame
	input wire rx_frame_done_i,
	input wire [47:0] rx_dest_addr_i,
	input wire [15:0] rx_len_type_i,
	input wire [CNT_W-1:0] rx_byte_count_i,
	input wire rx_symbol_err_i,
	input wire rx_short_i,
	input wire rx_fcs_err_i,
	input wire pass_bad_frame_i,
	input wire rx_head_release_i,
	output wire rx_head_free_o,
	output reg rx_frame_stored_o,
	// Transmit path
	input wire tx_frame_pending_i,
	input wire [CNT_W-1:0] tx_bytes_written_i,
	input wire tx_frame_written_i,
	input wire tx_frame_sent_i,
	output reg tx_start_o,
	output wire irq_o
);

	// ************************************************************
	// Shared decoding
	// ************************************************************

	// Frame longer than the largest legal size
	function over_limit;
		input [CNT_W-1:0] n;
		begin
			over_limit = (n > `MAX_FRAME_BYTES);
		end
	endfunction

	// Write strobe aimed at one register offset
	function write_hit;
		input strobe;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] ofs;
		begin
			write_hit = strobe & (a == ofs);
		end
	endfunction

	// ************************************************************
	// Frame classification
	// ************************************************************

	wire is_broadcast;
	wire is_group;
	wire is_bad;
	wire [15:0] new_status;

	// Broadcast from the whole destination address, group from bit 40 of the first octet
	assign is_broadcast = (rx_dest_addr_i == 48'hffffffffffff);
	assign is_group = rx_dest_addr_i[40];
	// Oversize, short and FCS frames count as bad
	assign is_bad = rx_short_i | rx_fcs_err_i | over_limit(rx_byte_count_i);

	// Status word stored with the frame
	assign new_status = {1'b1,
		7'h00,
		is_broadcast,
		is_group,
		~is_group,
		rx_symbol_err_i,
		(rx_len_type_i > `TYPE_FIELD_LIMIT),
		over_limit(rx_byte_count_i),
		rx_short_i,
		rx_fcs_err_i};

	// ************************************************************
	// Head of receive queue
	// ************************************************************

	reg head_valid_q;
	reg [14:0] head_status_q;
	reg [CNT_W-1:0] head_count_q;
	wire accept;
	wire discard;
	wire overrun;

	assign rx_head_free_o = ~head_valid_q;
	assign discard = rx_frame_done_i & is_bad & ~pass_bad_frame_i;
	assign accept = rx_frame_done_i & ~discard & ~head_valid_q;
	assign overrun = rx_frame_done_i & ~discard & head_valid_q;

	// Load on an accepted frame while empty, empty on release; valid low until loaded
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			head_valid_q <= 1'b0;
			head_status_q <= 15'h0000;
			head_count_q <= {CNT_W{1'b0}};
			rx_frame_stored_o <= 1'b0;
		end else begin
			rx_frame_stored_o <= accept;
			if (accept) begin
				head_valid_q <= 1'b1;
				head_status_q <= new_status[14:0];
				head_count_q <= rx_byte_count_i;
			end else if (rx_head_release_i) begin
				head_valid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Early transmit control
	// ************************************************************

	reg etx_en_q;
	reg [`ETX_THR_MSB:0] etx_thr_q;
	reg tx_started_q;
	wire [CNT_W:0] thr_bytes;
	wire start_now;

	assign thr_bytes = {{(CNT_W-5-`ETX_THR_UNIT_SHIFT+1){1'b0}}, etx_thr_q,
		{`ETX_THR_UNIT_SHIFT{1'b0}}};
	assign start_now = tx_frame_pending_i & ~tx_started_q &
		(etx_en_q ? ({1'b0, tx_bytes_written_i} > thr_bytes)
			: tx_frame_written_i);

	// Start one packet once, rearm when it has gone out
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_started_q <= 1'b0;
			tx_start_o <= 1'b0;
		end else begin
			tx_start_o <= start_now;
			if (tx_frame_sent_i)
				tx_started_q <= 1'b0;
			else if (start_now)
				tx_started_q <= 1'b1;
		end
	end

	// ************************************************************
	// Registers and interrupt
	// ************************************************************

	reg [`IRQ_WIDTH-1:0] irq_stat_q;
	reg [`IRQ_WIDTH-1:0] irq_en_q;
	wire [`IRQ_WIDTH-1:0] irq_evt;
	wire [`IRQ_WIDTH-1:0] irq_clr;

	assign irq_evt = {start_now, overrun, discard, accept};
	assign irq_clr = write_hit(wr_i, addr_i, `OFS_IRQ_CLEAR) ? wdata_i[`IRQ_WIDTH-1:0]
		: {`IRQ_WIDTH{1'b0}};
	assign irq_o = |(irq_stat_q & irq_en_q);

	// Writes; event set wins over clear
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			etx_en_q <= `ETX_ENABLE_RESET;
			etx_thr_q <= `ETX_THR_RESET;
			irq_stat_q <= {`IRQ_WIDTH{1'b0}};
			irq_en_q <= {`IRQ_WIDTH{1'b0}};
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
			if (write_hit(wr_i, addr_i, `OFS_EARLY_TX)) begin
				etx_en_q <= wdata_i[`BIT_ETX_ENABLE];
				etx_thr_q <= wdata_i[`ETX_THR_MSB:0];
			end
			if (write_hit(wr_i, addr_i, `OFS_IRQ_ENABLE))
				irq_en_q <= wdata_i[`IRQ_WIDTH-1:0];
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				`OFS_RX_STATUS: rdata_o <= head_valid_q ? {1'b1, head_status_q}
					: 16'h0000;
				`OFS_RX_BYTE_COUNT: rdata_o <= {{(16-CNT_W){1'b0}}, head_count_q};
				`OFS_EARLY_TX: rdata_o <= {8'h00, etx_en_q, 2'h0, etx_thr_q};
				`OFS_IRQ_STATUS: rdata_o <= {{(16-`IRQ_WIDTH){1'b0}}, irq_stat_q};
				`OFS_IRQ_ENABLE: rdata_o <= {{(16-`IRQ_WIDTH){1'b0}}, irq_en_q};
				default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

endmodule // rx_status_early_tx_regs
`default_nettype wire

// *** verification/regs_monitor.sv ***
// Port checker of the queue register bank
`default_nettype none
module regs_monitor (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] rdata_o,
	input wire logic rx_frame_done_i,
	input wire logic rx_short_i,
	input wire logic rx_fcs_err_i,
	input wire logic [10:0] rx_byte_count_i,
	input wire logic pass_bad_frame_i,
	input wire logic rx_head_free_o,
	input wire logic rx_frame_stored_o,
	input wire logic tx_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Accepted frame: one stored pulse, head slot taken
	sequence s_store; rx_frame_stored_o && !rx_head_free_o ##1 !rx_frame_stored_o; endsequence
	property p_good; rx_frame_done_i && rx_head_free_o && !rx_short_i && !rx_fcs_err_i &&
		rx_byte_count_i <= 11'h77c |=> s_store; endproperty
	a_good: assert property (p_good) else $error("frame not stored");
	property p_bad; rx_frame_done_i && !pass_bad_frame_i && (rx_short_i || rx_fcs_err_i)
		|=> !rx_frame_stored_o; endproperty
	a_bad: assert property (p_bad) else $error("bad frame stored");
	property p_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_empty; rd_i && addr_i == 8'h04 && rx_head_free_o |=> rdata_o == 16'h0000; endproperty
	a_empty: assert property (p_empty) else $error("status without frame");
	property p_full; rd_i && addr_i == 8'h04 && !rx_head_free_o
		|=> rdata_o[15] && rdata_o[6] != rdata_o[5]; endproperty
	a_full: assert property (p_full) else $error("status of head frame");
	property p_count; rd_i && addr_i == 8'h06 |=> rdata_o[15:11] == 5'h00; endproperty
	a_count: assert property (p_count) else $error("count upper bits");
	property p_etx; rd_i && addr_i == 8'h08 |=> rdata_o[15:8] == 8'h00 && rdata_o[6:5] == 2'h0;
	endproperty
	a_etx: assert property (p_etx) else $error("early tx reserved bits");
	property p_pulse; tx_start_o |=> !tx_start_o; endproperty
	a_pulse: assert property (p_pulse) else $error("start not a pulse");
endmodule // regs_monitor
`default_nettype wire

// *** verification/frame_source.sv ***
// Receive path model handing finished frames to the bank
`default_nettype none
module frame_source (
	input wire logic clk_i,
	output var logic rx_frame_done_i = 1'h0,
	output var logic [47:0] rx_dest_addr_i = 48'h0,
	output var logic [15:0] rx_len_type_i = 16'h0,
	output var logic [10:0] rx_byte_count_i = 11'h0,
	output var logic rx_symbol_err_i = 1'h0,
	output var logic rx_short_i = 1'h0,
	output var logic rx_fcs_err_i = 1'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Fields hold only with the done pulse, inverted after it
	task automatic send(input logic [47:0] da, input logic [15:0] lt, input logic [10:0] n,
		input logic [2:0] e);
		@(posedge clk_i);
		rx_frame_done_i <= 1'h1;
		{rx_dest_addr_i, rx_len_type_i, rx_byte_count_i} <= {da, lt, n};
		{rx_symbol_err_i, rx_short_i, rx_fcs_err_i} <= e;
		@(posedge clk_i);
		rx_frame_done_i <= 1'h0;
		{rx_dest_addr_i, rx_len_type_i, rx_byte_count_i} <= ~{da, lt, n};
		{rx_symbol_err_i, rx_short_i, rx_fcs_err_i} <= ~e;
	endtask
endmodule // frame_source
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the queue register bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = '0, resetn_i = '0, wr_i = '0, rd_i = '0, pass_bad_frame_i = '0;
	logic rx_head_release_i = '0, tx_frame_pending_i = '0, tx_frame_written_i = '0;
	logic tx_frame_sent_i = '0, rx_frame_done_i, rx_symbol_err_i, rx_short_i, rx_fcs_err_i;
	logic rx_head_free_o, rx_frame_stored_o, tx_start_o, irq_o;
	logic [7:0] addr_i = '0;
	logic [10:0] tx_bytes_written_i = '0, rx_byte_count_i;
	logic [15:0] wdata_i = '0, rdata_o, rx_len_type_i;
	logic [47:0] rx_dest_addr_i;
	int n_fail = 0, samples_checked = 0;
	rx_status_early_tx_regs i_dut (.*);
	frame_source i_src (.*);
	initial forever #2 clk_i = ~clk_i;
	initial begin
		#20us;
		n_fail++;
		conclude();
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One write, or one read judged against d
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		{wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
		@(posedge clk_i);
		{wr_i, rd_i} <= 2'h0;
		if (!w) @(negedge clk_i);
		if (!w) chk("read data", rdata_o, d);
	endtask
	task automatic release_head();
		@(posedge clk_i);
		rx_head_release_i <= '1;
		@(posedge clk_i);
		rx_head_release_i <= '0;
	endtask
	task automatic t_regs();
		bus(0, 8'h08, 16'h0000);
		bus(0, 8'h04, 16'h0000);
		bus(0, 8'h02, 16'h0000);
		bus(1, 8'h06, 16'hffff);
		bus(0, 8'h06, 16'h0000);
		bus(1, 8'h08, 16'hffff);
		bus(0, 8'h08, 16'h009f);
	endtask
	task automatic t_rx();
		bus(1, 8'h14, 16'h0001);
		i_src.send(48'hffffffffffff, 16'h0800, 11'h064, 3'h4);
		bus(0, 8'h04, 16'h80d8);
		bus(0, 8'h06, 16'h0064);
		chk("irq", irq_o, 16'h0001);
		bus(1, 8'h12, 16'h0001);
		@(negedge clk_i);
		chk("irq", irq_o, 16'h0000);
		release_head();
		bus(0, 8'h04, 16'h0000);
		chk("head free", rx_head_free_o, 16'h0001);
		@(posedge clk_i);
		pass_bad_frame_i <= '1;
		i_src.send(48'h020000000001, 16'h05dc, 11'h77d, 3'h0);
		bus(0, 8'h04, 16'h8024);
		bus(0, 8'h06, 16'h077d);
		release_head();
		i_src.send(48'h010000000000, 16'h05dd, 11'h040, 3'h3);
		bus(0, 8'h04, 16'h804b);
		i_src.send(48'h020000000001, 16'h0040, 11'h040, 3'h0);
		bus(0, 8'h04, 16'h804b);
		release_head();
		pass_bad_frame_i <= '0;
		i_src.send(48'h020000000001, 16'h0040, 11'h040, 3'h1);
		bus(0, 8'h04, 16'h0000);
		bus(0, 8'h10, 16'h0007);
	endtask
	task automatic t_tx();
		bus(1, 8'h08, 16'h0082);
		tx_bytes_written_i <= 11'h080;
		tx_frame_pending_i <= '1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("tx start", tx_start_o, 16'h0000);
		@(posedge clk_i);
		tx_bytes_written_i <= 11'h081;
		@(negedge clk_i);
		@(negedge clk_i);
		chk("tx start", tx_start_o, 16'h0001);
		bus(1, 8'h08, 16'h0002);
		tx_frame_sent_i <= '1;
		@(posedge clk_i);
		tx_frame_sent_i <= '0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("tx start", tx_start_o, 16'h0000);
		@(posedge clk_i);
		tx_frame_written_i <= '1;
		@(negedge clk_i);
		@(negedge clk_i);
		chk("tx start", tx_start_o, 16'h0001);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		resetn_i <= '1;
		t_regs();
		t_rx();
		t_tx();
		conclude();
	end
endmodule // testbench
bind rx_status_early_tx_regs regs_monitor u_mon (.*);
`default_nettype wire
